/* bench/rtu_line_master.sv */
// Behavioural bus master on the far side of the serial line
`timescale 1ns/1ps
module rtu_line_master #(
  parameter int bit_cyc = 763
) (
  // Clock
  input wire logic mclk,
  // Device driver
  input wire logic line_tx,
  input wire logic line_tx_oe,
  // Wire level
  output logic line_rx
);
  logic drv = 1'b1;
  assign line_rx = line_tx_oe ? line_tx : drv;
  task automatic send_char(input logic [7:0] b, input logic odd);
    logic [10:0] f;
    f = {1'b1, ^b ^ odd, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge mclk);
      drv <= f[i];
      repeat (bit_cyc - 1) @(posedge mclk);
    end
  endtask
  task automatic get_char(input logic odd, output logic [7:0] b, output logic ok);
    int n;
    logic [10:0] f;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    while (line_rx !== 1'b0 && n < 40000) begin
      @(posedge mclk);
      n++;
    end
    if (n < 40000) begin
      repeat (bit_cyc / 2) @(posedge mclk);
      for (int i = 0; i < 11; i++) begin
        f[i] = line_rx;
        // Stop at mid stop bit so the next start edge is not missed
        if (i < 10) repeat (bit_cyc) @(posedge mclk);
      end
      b = f[8:1];
      ok = (f[0] === 1'b0) && (f[10] === 1'b1) && (f[9] === (^b ^ odd)) && (line_tx_oe === 1'b1);
    end
  endtask
endmodule

/* bench/rtu_serial_framer_bench.sv */
// Self-checking bench for the serial frame layer
`timescale 1ns/1ps
module rtu_serial_framer_bench
  import rtu_framer_pkg::*;
;
  // Highest rate the 16-bit setting holds keeps the run short
  // Divider truncates 50 MHz over 65535 to 762 cycles
  localparam int bit_cyc = 762;
  localparam int char_cyc = 11 * bit_cyc;
  logic mclk;
  logic reset_n;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata;
  logic reg_write;
  logic reg_read;
  logic [15:0] reg_rdata;
  logic line_rx;
  logic line_tx;
  logic line_tx_oe;
  int n_mismatch;
  int comparisons;
  rtu_serial_framer rtu_serial_framer_i (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .line_rx(line_rx), .line_tx(line_tx), .line_tx_oe(line_tx_oe));
  rtu_line_master #(.bit_cyc(bit_cyc)) rtu_line_master_i (.mclk(mclk), .line_tx(line_tx),
    .line_tx_oe(line_tx_oe), .line_rx(line_rx));
  always #10 mclk = ~mclk;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic complete_run;
    if (n_mismatch == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) r = r[0] ? ((r >> 1) ^ 16'ha001) : (r >> 1);
    return r;
  endfunction
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [15:0] mask, input logic [15:0] exp);
    @(posedge mclk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 check(reg_rdata & mask, exp);
  endtask
  // Write followed at once by a read of the same place
  task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, input logic [15:0] exp);
    @(posedge mclk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_write <= 1'b0;
    reg_read <= 1'b1;
    @(posedge mclk);
    reg_read <= 1'b0;
    #1 check(reg_rdata, exp);
  endtask
  task automatic wait_oe(input logic lvl);
    int n;
    n = 0;
    while (line_tx_oe !== lvl && n < 6 * char_cyc) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 6 * char_cyc) begin
      n_mismatch++;
      complete_run();
    end
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rdc(reg_config, 16'hffff, 16'h0001);
    rdc(reg_rate, 16'hffff, 16'h4b00);
    rdc(reg_status, 16'hffff, 16'h0000);
    rdc(4'hc, 16'hffff, 16'h0000);
    check({line_tx, line_tx_oe, 14'h0}, 16'h8000);
  endtask
  task automatic t_setup;
    wr_rd(reg_config, 16'h0111, 16'h0111);
    wr_rd(reg_rate, 16'hffff, 16'hffff);
  endtask
  task automatic t_rx_frame;
    logic [15:0] c;
    c = crc_byte(crc_byte(crc_preset, 8'h11), fn_read);
    rtu_line_master_i.send_char(8'h11, 1'b0);
    rtu_line_master_i.send_char(fn_read, 1'b0);
    rtu_line_master_i.send_char(c[7:0], 1'b0);
    rtu_line_master_i.send_char(c[15:8], 1'b0);
    repeat (char_cyc * 7 / 2 + 400) @(posedge mclk);
    rdc(reg_status, 16'h00de, 16'h0002);
    rdc(reg_rx_crc, 16'hffff, c);
    rdc(reg_rx_data, 16'hffff, {8'h00, c[15:8]});
    rdc(reg_status, 16'h0001, 16'h0000);
    wr(reg_status, 16'h001f);
    rdc(reg_status, 16'h001e, 16'h0000);
  endtask
  task automatic t_tx;
    logic [15:0] c;
    logic [7:0] b;
    logic ok;
    c = crc_byte(crc_preset, 8'ha5);
    wr(reg_tx_data, 16'h01a5);
    wait_oe(1'b1);
    rdc(reg_status, 16'h0020, 16'h0020);
    rtu_line_master_i.get_char(1'b0, b, ok);
    check({7'h0, ok, b}, {8'h01, 8'ha5});
    rtu_line_master_i.get_char(1'b0, b, ok);
    check({7'h0, ok, b}, {8'h01, c[7:0]});
    rtu_line_master_i.get_char(1'b0, b, ok);
    check({7'h0, ok, b}, {8'h01, c[15:8]});
    wait_oe(1'b0);
    check({15'h0, line_tx}, 16'h0001);
  endtask
  // Odd sense selected, even-parity character sent
  task automatic t_parity;
    wr(reg_config, 16'h0311);
    rtu_line_master_i.send_char(8'h11, 1'b0);
    rdc(reg_status, 16'h0018, 16'h0008);
    wr(reg_status, 16'h0008);
    rdc(reg_status, 16'h0008, 16'h0000);
  endtask
  initial begin
    mclk = 1'b0;
    reset_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    n_mismatch = 0;
    comparisons = 0;
    repeat (6) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset();
    t_setup();
    t_rx_frame();
    t_tx();
    t_parity();
    complete_run();
  end
endmodule

/* bench/rtu_serial_framer_chk.sv */
// Port-level assertions for the serial frame layer
`timescale 1ns/1ps
module rtu_serial_framer_chk
  import rtu_framer_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [15:0] reg_rdata,
  // Line
  input wire logic line_rx,
  input wire logic line_tx,
  input wire logic line_tx_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Sequences
  // ----------------------------------------
  sequence cfg_wr_rd;
    reg_write && reg_addr == reg_config ##1 reg_read && reg_addr == reg_config;
  endsequence
  sequence level_change;
    line_tx_oe && $changed(line_tx);
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  rdata_idle_a: assert property (!reg_read |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside read answer");
  unmapped_zero_a: assert property (reg_read && reg_addr > reg_rx_crc |=> reg_rdata == 16'h0000)
    else $error("unmapped register read not zero");
  cfg_echo_a: assert property (cfg_wr_rd |=> reg_rdata == ($past(reg_wdata, 2) & 16'h07ff))
    else $error("config readback differs from write");
  status_width_a: assert property (reg_read && reg_addr == reg_status |=> reg_rdata[15:8] == 8'h00)
    else $error("status upper bits set");
  busy_oe_a: assert property (reg_read && reg_addr == reg_status && line_tx_oe |=> reg_rdata[st_tx_busy])
    else $error("driving line without busy flag");
  idle_high_a: assert property (!line_tx_oe |-> line_tx)
    else $error("transmit level low while released");
  oe_start_a: assert property ($rose(line_tx_oe) |-> ##[0:1] !line_tx)
    else $error("no start bit after enabling driver");
  bit_hold_a: assert property (level_change |=> $stable(line_tx) [*7])
    else $error("transmit bit shorter than eight cycles");
  release_high_a: assert property ($fell(line_tx_oe) |-> $past(line_tx) && line_tx)
    else $error("driver released outside stop level");
endmodule
bind rtu_serial_framer rtu_serial_framer_chk rtu_serial_framer_chk_i (
  .mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .line_rx(line_rx), .line_tx(line_tx), .line_tx_oe(line_tx_oe));

/* hdl/rtu_crc16.sv */
// Bytewise reflected 16-bit check value step
`timescale 1ns/1ps
module rtu_crc16
  import rtu_framer_pkg::*;
(
  // Inputs
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data,
  // Result
  output logic [15:0] crc_out
);
  always_comb begin
    logic [15:0] c;
    c = crc_in ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      if (c[0]) begin
        c = (c >> 1) ^ crc_poly;
      end else begin
        c = c >> 1;
      end
    end
    crc_out = c;
  end
endmodule

/* hdl/rtu_framer_pkg.sv */
// Constants shared by the serial frame layer
package rtu_framer_pkg;
  localparam int unsigned clk_hz = 50000000;
  localparam int unsigned rate_default = 19200;
  // Character times in tenths of a character
  localparam int unsigned end_gap_tenths = 35;
  localparam int unsigned abort_gap_tenths = 15;
  localparam logic [15:0] crc_preset = 16'hffff;
  localparam logic [15:0] crc_poly = 16'ha001;
  localparam logic [7:0] broadcast_addr = 8'h00;
  localparam logic [7:0] max_addr = 8'hf7;
  localparam logic [7:0] fn_read = 8'h03;
  localparam logic [7:0] fn_write = 8'h06;
  localparam logic [3:0] bits_data7 = 4'h7;
  localparam logic [3:0] bits_data8 = 4'h8;
  localparam logic [3:0] bits_per_char7 = 4'ha;
  localparam logic [3:0] bits_per_char8 = 4'hb;
  // Register offsets
  localparam logic [3:0] reg_config = 4'h0;
  localparam logic [3:0] reg_rate = 4'h1;
  localparam logic [3:0] reg_status = 4'h2;
  localparam logic [3:0] reg_rx_data = 4'h3;
  localparam logic [3:0] reg_tx_data = 4'h4;
  localparam logic [3:0] reg_rx_crc = 4'h5;
  // Config fields
  localparam int unsigned cfg_addr_lsb = 0;
  localparam int unsigned cfg_par_en = 8;
  localparam int unsigned cfg_par_odd = 9;
  localparam int unsigned cfg_data7 = 10;
  localparam logic [10:0] cfg_reset = 11'h001;
  // Status bits
  localparam int unsigned st_rx_valid = 0;
  localparam int unsigned st_frame_ok = 1;
  localparam int unsigned st_frame_bad = 2;
  localparam int unsigned st_parity_err = 3;
  localparam int unsigned st_framing_err = 4;
  localparam int unsigned st_tx_busy = 5;
  localparam int unsigned st_broadcast = 6;
  localparam int unsigned st_in_frame = 7;
  localparam int unsigned st_width = 8;
  // Transmit data word: bit 8 marks the last byte before the check field
  localparam int unsigned tx_last_bit = 8;
endpackage

/* hdl/rtu_serial_framer.sv */
// Character and frame layer of a serial slave on a half-duplex line
`timescale 1ns/1ps
// Functional notes
// - Drive line only while transmitting
// - Bit timing from bits-per-second setting
// - Start bit, 7/8 data, LSB first
// - Optional odd or even parity bit
// - One stop with parity, two without; seven-bit check bytes carry eight bits, leaving one stop or none
// - Eight data bits: eleven bit periods
// - Seven data bits: ten bit periods
// - Bytes carry binary, not text digits
// - Idle 3.5 characters before new frame
// - Order: address, function, data, check
// - First byte after idle is address
// - Silence 3.5 characters ends frame
// - Gap over 1.5 characters discards frame
// - Merged frames fail check, reported fault
// - Address 0..247, zero is broadcast
// - Function 03H read, 06H write
// - Data field is 2N bytes
// - Check value low byte first
// - Preset all ones, data bits only; seven-bit mode feeds bit 7 of back-to-back tx bytes in too
// - Xor byte, shift eight times
// - Parity sense; mismatch flags error
// - No reply to broadcast frames
module rtu_serial_framer
  import rtu_framer_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata,
  // Line
  input wire logic line_rx,
  output logic line_tx,
  output logic line_tx_oe
);
  // ---------------------------------------------
  // Registers
  // ---------------------------------------------
  logic [10:0] config_q;
  logic [15:0] serial_rate_setting;
  logic [st_width-1:0] status;
  logic [7:0] rx_data;
  logic [15:0] rx_crc;
  logic [7:0] own_addr;
  logic par_en, par_odd, data7;
  logic [3:0] data_bits, char_bits;
  logic [31:0] bit_cycles, half_cycles, end_gap_cycles, abort_gap_cycles;

  assign own_addr = config_q[cfg_addr_lsb +: 8];
  assign par_en = config_q[cfg_par_en];
  assign par_odd = config_q[cfg_par_odd];
  assign data7 = config_q[cfg_data7];
  assign data_bits = data7 ? bits_data7 : bits_data8;
  assign char_bits = data7 ? bits_per_char7 : bits_per_char8;

  // cycles per bit from rate
  // Divide is costly but only tracks a rarely written setting
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bit_cycles <= 32'(clk_hz / rate_default);
    end else if (serial_rate_setting == 16'h0000) begin
      bit_cycles <= 32'h0000_0001;
    end else begin
      bit_cycles <= clk_hz / {16'h0000, serial_rate_setting};
    end
  end
  assign half_cycles = bit_cycles >> 1;
  assign end_gap_cycles = (bit_cycles * {28'h0, char_bits} * end_gap_tenths) / 10;
  assign abort_gap_cycles = (bit_cycles * {28'h0, char_bits} * abort_gap_tenths) / 10;

  // ---------------------------------------------
  // Input synchroniser
  // ---------------------------------------------
  logic [2:0] rx_sync;
  logic rx_level;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_sync <= 3'h7;
      rx_level <= 1'b1;
    end else begin
      rx_sync <= {rx_sync[1:0], line_rx};
      if (rx_sync[1] == rx_sync[2]) begin
        rx_level <= rx_sync[2];
      end
    end
  end

  // ---------------------------------------------
  // Character receiver
  // ---------------------------------------------
  typedef enum logic [1:0] {rx_idle = 2'b00, rx_bits = 2'b01, rx_done = 2'b11} rx_state_e;
  rx_state_e rx_state;
  logic [31:0] rx_cnt;
  logic [3:0] rx_idx;
  logic [10:0] rx_shift;
  logic char_valid, char_par_err, char_frm_err;
  logic [7:0] char_byte;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rx_state <= rx_idle;
      rx_cnt <= 32'h0;
      rx_idx <= 4'h0;
      rx_shift <= 11'h0;
      char_valid <= 1'b0;
      char_byte <= 8'h00;
      char_par_err <= 1'b0;
      char_frm_err <= 1'b0;
    end else begin
      char_valid <= 1'b0;
      unique case (rx_state)
        rx_idle: begin
          rx_idx <= 4'h0;
          if (!rx_level) begin
            rx_state <= rx_bits;
            rx_cnt <= half_cycles;
          end
        end
        rx_bits: begin
          if (rx_cnt != 32'h0) begin
            rx_cnt <= rx_cnt - 32'h1;
          end else begin
            rx_cnt <= bit_cycles - 32'h1;
            rx_shift[rx_idx] <= rx_level;
            if (rx_idx == 4'h0 && rx_level) begin
              rx_state <= rx_idle;
            end else if (rx_idx == char_bits - 4'h1) begin
              rx_state <= rx_done;
            end else begin
              rx_idx <= rx_idx + 4'h1;
            end
          end
        end
        rx_done: begin
          char_valid <= 1'b1;
          char_byte <= data7 ? {1'b0, rx_shift[7:1]} : rx_shift[8:1];
          char_par_err <= par_en &
            ((data7 ? (^rx_shift[8:1]) : (^rx_shift[9:1])) != par_odd);
          char_frm_err <= !rx_shift[char_bits - 4'h1] |
            (!par_en & !rx_shift[char_bits - 4'h2]);
          rx_state <= rx_idle;
        end
      endcase
    end
  end

  // ---------------------------------------------
  // Frame delimiting and check
  // ---------------------------------------------
  logic [31:0] silence;
  logic in_frame, frame_bad, frame_broadcast, frame_first;
  logic gap_long;
  logic [15:0] crc_acc, crc_next;
  logic [7:0] hold0, hold1;
  logic [1:0] held;

  rtu_crc16 u_crc (
    .crc_in(crc_acc),
    .data(hold1),
    .crc_out(crc_next)
  );

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      silence <= 32'h0;
    end else if (rx_state != rx_idle || char_valid) begin
      silence <= 32'h0;
    end else if (silence != 32'hffff_ffff) begin
      silence <= silence + 32'h1;
    end
  end

  // remember long gap
  // Silence is cleared while a byte arrives, so the gap must be kept until it lands
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      gap_long <= 1'b0;
    end else if (char_valid) begin
      gap_long <= 1'b0;
    end else if (rx_state == rx_idle && silence > abort_gap_cycles) begin
      gap_long <= 1'b1;
    end
  end

  logic frame_end;
  assign frame_end = in_frame && silence == end_gap_cycles;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      in_frame <= 1'b0;
      frame_first <= 1'b1;
      frame_bad <= 1'b0;
      frame_broadcast <= 1'b0;
      crc_acc <= crc_preset;
      hold0 <= 8'h00;
      hold1 <= 8'h00;
      held <= 2'h0;
      rx_crc <= 16'h0;
    end else if (char_valid) begin
      if (!in_frame || gap_long) begin
        in_frame <= 1'b1;
        frame_bad <= char_par_err | char_frm_err |
          (char_byte != own_addr && char_byte != broadcast_addr);
        frame_broadcast <= char_byte == broadcast_addr;
        crc_acc <= crc_preset;
        hold0 <= char_byte;
        held <= 2'h1;
      end else begin
        frame_bad <= frame_bad | char_par_err | char_frm_err;
        hold0 <= char_byte;
        hold1 <= hold0;
        if (held == 2'h2) begin
          crc_acc <= crc_next;
        end else begin
          held <= held + 2'h1;
        end
      end
    end else if (frame_end) begin
      in_frame <= 1'b0;
      rx_crc <= {hold0, hold1};
    end
  end

  // Two-stage hold keeps the trailing check bytes out of the running value
  function automatic logic [15:0] u_crc_in_delay(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ crc_poly) : (r >> 1);
    end
    return r;
  endfunction

  // ---------------------------------------------
  // Status and receive data
  // ---------------------------------------------
  logic frame_ok_now;
  assign frame_ok_now = !frame_bad && held == 2'h2 && {hold0, hold1} == crc_acc;

  logic tx_busy;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status <= '0;
      rx_data <= 8'h00;
    end else begin
      status[st_in_frame] <= in_frame;
      status[st_tx_busy] <= tx_busy;
      if (char_valid) begin
        rx_data <= char_byte;
        status[st_rx_valid] <= 1'b1;
      end else if (reg_read && reg_addr == reg_rx_data) begin
        status[st_rx_valid] <= 1'b0;
      end
      if (char_valid && char_par_err) begin
        status[st_parity_err] <= 1'b1;
      end else if (reg_write && reg_addr == reg_status) begin
        status[st_parity_err] <= status[st_parity_err] & ~reg_wdata[st_parity_err];
      end
      if (char_valid && char_frm_err) begin
        status[st_framing_err] <= 1'b1;
      end else if (reg_write && reg_addr == reg_status) begin
        status[st_framing_err] <= status[st_framing_err] & ~reg_wdata[st_framing_err];
      end
      if (frame_end) begin
        status[st_frame_ok] <= frame_ok_now;
        status[st_frame_bad] <= !frame_ok_now;
        status[st_broadcast] <= frame_broadcast;
      end else if (reg_write && reg_addr == reg_status) begin
        status[st_frame_ok] <= status[st_frame_ok] & ~reg_wdata[st_frame_ok];
        status[st_frame_bad] <= status[st_frame_bad] & ~reg_wdata[st_frame_bad];
      end
    end
  end

  // ---------------------------------------------
  // Register port
  // ---------------------------------------------
  logic tx_req;
  logic tx_take;
  logic [8:0] tx_word;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      config_q <= cfg_reset;
      serial_rate_setting <= 16'(rate_default);
      tx_req <= 1'b0;
      tx_word <= 9'h000;
    end else begin
      // Request stands until the transmitter takes it
      if (tx_take) begin
        tx_req <= 1'b0;
      end
      if (reg_write) begin
        unique case (reg_addr)
          reg_config: config_q <= reg_wdata[10:0];
          reg_rate: serial_rate_setting <= reg_wdata;
          reg_tx_data: begin
            tx_req <= !status[st_broadcast];
            tx_word <= reg_wdata[8:0];
          end
          default: ;
        endcase
      end
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 16'h0;
    end else if (reg_read) begin
      unique case (reg_addr)
        reg_config: reg_rdata <= {5'h00, config_q};
        reg_rate: reg_rdata <= serial_rate_setting;
        reg_status: reg_rdata <= {8'h00, status};
        reg_rx_data: reg_rdata <= {8'h00, rx_data};
        reg_rx_crc: reg_rdata <= rx_crc;
        default: reg_rdata <= 16'h0;
      endcase
    end else begin
      reg_rdata <= 16'h0;
    end
  end

  // ---------------------------------------------
  // Transmitter
  // ---------------------------------------------
  typedef enum logic [1:0] {tx_idle = 2'b00, tx_gap = 2'b01, tx_shift = 2'b11, tx_check = 2'b10} tx_state_e;
  tx_state_e tx_state;
  logic [31:0] tx_cnt, tx_quiet;
  logic [3:0] tx_idx;
  logic [11:0] tx_frame;
  logic [15:0] tx_crc;
  logic tx_last, tx_crc_hi;

  assign tx_busy = tx_state != tx_idle || tx_req;
  assign tx_take = tx_req && (tx_state == tx_idle ||
    (tx_state == tx_shift && tx_cnt == 32'h0 && tx_idx == char_bits - 4'h1));

  // parity bit insertion
  // Builds start, data LSB first, optional parity and stop bits
  function automatic logic [11:0] pack_char(input logic [7:0] b, input logic d7, input logic pe, input logic po);
    logic [7:0] m;
    logic p;
    m = d7 ? {1'b0, b[6:0]} : b;
    p = (^m) ^ po;
    if (d7) begin
      pack_char = pe ? {3'h7, p, m[6:0], 1'b0} : {3'h7, 1'b1, m[6:0], 1'b0};
    end else begin
      pack_char = pe ? {2'h3, p, m, 1'b0} : {2'h3, 1'b1, m, 1'b0};
    end
  endfunction

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_quiet <= 32'h0;
    end else if (line_tx_oe || rx_state != rx_idle) begin
      tx_quiet <= 32'h0;
    end else if (tx_quiet != 32'hffff_ffff) begin
      tx_quiet <= tx_quiet + 32'h1;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_state <= tx_idle;
      tx_cnt <= 32'h0;
      tx_idx <= 4'h0;
      tx_frame <= 12'hfff;
      tx_crc <= crc_preset;
      tx_last <= 1'b0;
      tx_crc_hi <= 1'b0;
      line_tx <= 1'b1;
      line_tx_oe <= 1'b0;
    end else begin
      unique case (tx_state)
        tx_idle: begin
          line_tx <= 1'b1;
          line_tx_oe <= 1'b0;
          if (tx_req) begin
            tx_frame <= pack_char(tx_word[7:0], data7, par_en, par_odd);
            tx_last <= tx_word[tx_last_bit];
            tx_state <= tx_gap;
          end
        end
        tx_gap: begin
          if (tx_quiet >= end_gap_cycles) begin
            tx_crc <= u_crc_in_delay(crc_preset, tx_frame[8:1] & (data7 ? 8'h7f : 8'hff));
            tx_state <= tx_shift;
            tx_idx <= 4'h0;
            tx_cnt <= bit_cycles - 32'h1;
            line_tx_oe <= 1'b1;
            line_tx <= tx_frame[0];
          end
        end
        tx_shift, tx_check: begin
          if (tx_cnt != 32'h0) begin
            tx_cnt <= tx_cnt - 32'h1;
          end else if (tx_idx != char_bits - 4'h1) begin
            tx_cnt <= bit_cycles - 32'h1;
            tx_idx <= tx_idx + 4'h1;
            line_tx <= tx_frame[tx_idx + 4'h1];
          end else if (tx_state == tx_shift && tx_req) begin
            // Back-to-back bytes keep the frame continuous
            tx_frame <= pack_char(tx_word[7:0], data7, par_en, par_odd);
            tx_last <= tx_word[tx_last_bit];
            tx_crc <= u_crc_in_delay(tx_crc, tx_word[7:0]);
            tx_idx <= 4'h0;
            tx_cnt <= bit_cycles - 32'h1;
            line_tx <= 1'b0;
          end else if (tx_state == tx_shift && tx_last) begin
            tx_state <= tx_check;
            tx_crc_hi <= 1'b0;
            tx_frame <= pack_char(tx_crc[7:0], 1'b0, par_en, par_odd);
            tx_idx <= 4'h0;
            tx_cnt <= bit_cycles - 32'h1;
            line_tx <= 1'b0;
          end else if (tx_state == tx_check && !tx_crc_hi) begin
            tx_crc_hi <= 1'b1;
            tx_frame <= pack_char(tx_crc[15:8], 1'b0, par_en, par_odd);
            tx_idx <= 4'h0;
            tx_cnt <= bit_cycles - 32'h1;
            line_tx <= 1'b0;
          end else begin
            tx_state <= tx_idle;
            line_tx <= 1'b1;
            line_tx_oe <= 1'b0;
          end
        end
      endcase
    end
  end
endmodule
